// ==== hw/fcw_pkg.sv ====
// Overview of operation
// [RULE_01] Word at 2084h bits 9..0 hold the 10-bit sensor reading at 30 C.
// [RULE_02] Temperature word bits 13..10 always read as zero.
// [RULE_03] Firmware copies oscillator trim bits 6..0 of 2085h into register 198h.
// [RULE_04] With current-sense output path, firmware copies 2086h offset into 199h.
// [RULE_05] Word 2087h: internal-feedback gain trim bits 11..8, error offset bits 4..0.
// [RULE_06] Firmware always copies the five-bit error offset trim into 19Ch.
// [RULE_07] Internal feedback selected: firmware loads gain register 19Eh from 2087h.
// [RULE_08] Word 2088h: span trim bits 12..8, external-path gain trim bits 3..0.
// [RULE_09] Firmware copies the five-bit span trim into register 19Fh.
// [RULE_10] External sense path selected: gain register 19Eh comes from 2088h instead.
// [RULE_11] Oscillator/offset words read zero at 13..7; gain word at 13..12, 7..5.
// [RULE_12] Firmware completes all copies once per reset before enabling the loop.
package fcw_pkg;
	localparam int unsigned CW_W = 14;
	localparam int unsigned N_WORDS = 5;

	// printed word locations are indices; byte address is four times the index
	localparam logic [15:0] IDX_TEMP = 16'h2084;
	localparam logic [15:0] IDX_OSC = 16'h2085;
	localparam logic [15:0] IDX_OFFS = 16'h2086;
	localparam logic [15:0] IDX_GEO = 16'h2087;
	localparam logic [15:0] IDX_SPAN = 16'h2088;

	// block-own registers
	localparam logic [31:0] ADDR_CTRL = 32'h0000_8230;
	localparam logic [31:0] ADDR_STAT = 32'h0000_8234;
	localparam logic [31:0] ADDR_SEL = 32'h0000_8238;

	localparam logic [CW_W-1:0] MASK_TEMP = 14'h03FF;
	localparam logic [CW_W-1:0] MASK_OSC = 14'h007F;
	localparam logic [CW_W-1:0] MASK_OFFS = 14'h007F;
	localparam logic [CW_W-1:0] MASK_GEO = 14'h0F1F;
	localparam logic [CW_W-1:0] MASK_SPAN = 14'h1F0F;
	localparam logic [CW_W-1:0] ERASED = 14'h3FFF;

	localparam int unsigned TEMP_LSB = 0;
	localparam int unsigned OSC_LSB = 0;
	localparam int unsigned OFFS_LSB = 0;
	localparam int unsigned GAIN_INT_LSB = 8;
	localparam int unsigned EAOFF_LSB = 0;
	localparam int unsigned SPAN_LSB = 8;
	localparam int unsigned GAIN_EXT_LSB = 0;

	localparam int unsigned CTRL_FB_EXT_BIT = 0;
	localparam int unsigned CTRL_PROG_EN_BIT = 1;
	localparam int unsigned CTRL_LOCK_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int unsigned STAT_CNT_LSB = 8;
	localparam int unsigned SEL_EAOFF_LSB = 8;
	localparam int unsigned SEL_SPAN_LSB = 16;

	localparam logic [2:0] SLOT_NONE = 3'h7;

	typedef enum logic [2:0] {
		FCW_IDLE = 3'b001,
		FCW_WAIT = 3'b010,
		FCW_DONE = 3'b100
	} fcw_apb_st_t;

	function automatic logic [31:0] fcw_addr(input logic [15:0] idx);
		fcw_addr = {14'h0000, idx, 2'b00};
	endfunction

	function automatic logic [2:0] fcw_slot(input logic [31:0] addr);
		if (addr == fcw_addr(IDX_TEMP)) fcw_slot = 3'h0;
		else if (addr == fcw_addr(IDX_OSC)) fcw_slot = 3'h1;
		else if (addr == fcw_addr(IDX_OFFS)) fcw_slot = 3'h2;
		else if (addr == fcw_addr(IDX_GEO)) fcw_slot = 3'h3;
		else if (addr == fcw_addr(IDX_SPAN)) fcw_slot = 3'h4;
		else fcw_slot = SLOT_NONE;
	endfunction

	function automatic logic [CW_W-1:0] fcw_mask(input logic [2:0] slot);
		case (slot)
			3'h0: fcw_mask = MASK_TEMP;
			3'h1: fcw_mask = MASK_OSC;
			3'h2: fcw_mask = MASK_OFFS;
			3'h3: fcw_mask = MASK_GEO;
			3'h4: fcw_mask = MASK_SPAN;
			default: fcw_mask = 14'h0000;
		endcase
	endfunction
endpackage

// ==== hw/fcw_cal_store.sv ====
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module fcw_cal_store import fcw_pkg::*; #(
	// factory contents; erased flash reads all ones
	parameter logic [CW_W-1:0] FACT_TEMP = ERASED,
	parameter logic [CW_W-1:0] FACT_OSC = ERASED,
	parameter logic [CW_W-1:0] FACT_OFFS = ERASED,
	parameter logic [CW_W-1:0] FACT_GEO = ERASED,
	parameter logic [CW_W-1:0] FACT_SPAN = ERASED
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [9:0] TEMP_READING_30C,
	output logic [6:0] OSC_TRIM_FIELD,
	output logic [6:0] SENSE_OFFSET_FIELD,
	output logic [4:0] ERROR_AMP_OFFSET_TRIM,
	output logic [3:0] AMP_GAIN_TRIM,
	output logic [4:0] OVERVOLT_REF_SPAN_TRIM,
	output logic FB_EXTERNAL
);

	localparam logic [CW_W-1:0] FACT [0:N_WORDS-1] = '{FACT_TEMP, FACT_OSC, FACT_OFFS, FACT_GEO, FACT_SPAN};

	fcw_apb_st_t st_q;
	fcw_apb_st_t st_d;
	logic [CW_W-1:0] word_q [0:N_WORDS-1];
	logic fb_ext_q;
	logic prog_en_q;
	logic lock_q;
	logic [7:0] prog_cnt_q;
	logic [31:0] rdata_q;
	logic err_q;
	logic [2:0] slot;
	logic is_ctrl;
	logic is_stat;
	logic is_sel;
	logic mapped;
	logic prog_ok;
	logic wr_fault;
	logic commit;
	logic [CW_W-1:0] wr_word;
	logic [3:0] gain_sel;
	// write strobes, read images and field extractions
	logic ctrl_wr;
	logic cal_wr;
	logic [N_WORDS-1:0] word_we;
	logic [31:0] ctrl_view;
	logic [31:0] stat_view;
	logic [31:0] sel_view;
	logic [31:0] rd_view;
	logic [9:0] temp_field;
	logic [6:0] osc_field;
	logic [6:0] offs_field;
	logic [4:0] eaoff_field;
	logic [4:0] span_field;

	assign slot = fcw_slot(PADDR);
	assign is_ctrl = (PADDR == ADDR_CTRL);
	assign is_stat = (PADDR == ADDR_STAT);
	assign is_sel = (PADDR == ADDR_SEL);
	assign mapped = (slot != SLOT_NONE) || is_ctrl || is_stat || is_sel;
	assign prog_ok = prog_en_q && !lock_q;

	// cal words only take writes while programming is open; status and selection are read-only
	assign wr_fault = PWRITE && ((slot != SLOT_NONE && !prog_ok) || is_stat || is_sel);

	// two wait states so read data comes from a flip-flop
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			FCW_IDLE: begin
				if (PSEL && PENABLE) begin
					st_d = FCW_WAIT;
				end
			end
			FCW_WAIT: begin
				st_d = FCW_DONE;
			end
			FCW_DONE: begin
				st_d = FCW_IDLE;
			end
			default: begin
				st_d = FCW_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= FCW_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign PREADY = (st_q == FCW_DONE);
	assign PSLVERR = (st_q == FCW_DONE) && err_q;
	assign PRDATA = rdata_q;
	assign commit = (st_q == FCW_DONE) && PSEL && PENABLE && PWRITE && !err_q;
	assign ctrl_wr = commit && is_ctrl && PSTRB[0];
	assign cal_wr = commit && (slot != SLOT_NONE);

	// one enable per word so the store stays a plain indexed array
	always_comb begin
		word_we = '0;
		if (cal_wr) begin
			word_we[slot] = 1'b1;
		end
	end

	// refusal decided in the wait cycle; the master holds the request stable
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			err_q <= 1'b0;
		end else if (st_q == FCW_WAIT) begin
			err_q <= !mapped || wr_fault;
		end
	end

	// control, status and selection images
	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[CTRL_FB_EXT_BIT] = fb_ext_q;
		ctrl_view[CTRL_PROG_EN_BIT] = prog_en_q;
		ctrl_view[CTRL_LOCK_BIT] = lock_q;
	end

	always_comb begin
		stat_view = 32'h0000_0000;
		stat_view[CTRL_FB_EXT_BIT] = fb_ext_q;
		stat_view[CTRL_PROG_EN_BIT] = prog_ok;
		stat_view[CTRL_LOCK_BIT] = lock_q;
		stat_view[STAT_CNT_LSB +: 8] = prog_cnt_q;
	end

	always_comb begin
		sel_view = 32'h0000_0000;
		sel_view[3:0] = AMP_GAIN_TRIM;
		sel_view[SEL_EAOFF_LSB +: 5] = ERROR_AMP_OFFSET_TRIM;
		sel_view[SEL_SPAN_LSB +: 5] = OVERVOLT_REF_SPAN_TRIM;
	end

	// one read multiplexer; unmapped and write cycles answer with zero
	always_comb begin
		rd_view = 32'h0000_0000;
		if (!PWRITE) begin
			if (slot != SLOT_NONE) begin
				// unimplemented bits forced low here, not just at storage
				rd_view = {18'h00000, word_q[slot] & fcw_mask(slot)}; // RULE_01 RULE_02 RULE_11
			end else if (is_ctrl) begin
				rd_view = ctrl_view;
			end else if (is_stat) begin
				rd_view = stat_view;
			end else if (is_sel) begin
				rd_view = sel_view;
			end
		end
	end

	// read data from a flip-flop costs the extra wait state
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 32'h0000_0000;
		end else if (st_q == FCW_WAIT) begin
			rdata_q <= rd_view;
		end
	end

	// byte lanes: low lane carries bits 7..0, next lane bits 13..8
	always_comb begin
		wr_word = (slot != SLOT_NONE) ? word_q[slot] : 14'h0000;
		if (PSTRB[0]) begin
			wr_word[7:0] = PWDATA[7:0];
		end
		if (PSTRB[1]) begin
			wr_word[13:8] = PWDATA[13:8];
		end
	end

	// stored image keeps unimplemented bits clear so every consumer sees zeros
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < N_WORDS; i++) begin
				word_q[i] <= FACT[i] & fcw_mask(3'(i)); // RULE_02 RULE_11
			end
		end else begin
			for (int i = 0; i < N_WORDS; i++) begin
				if (word_we[i]) begin
					word_q[i] <= wr_word & fcw_mask(3'(i)); // RULE_05 RULE_08
				end
			end
		end
	end

	// path choice may change at any time, even when locked
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fb_ext_q <= CTRL_RST[CTRL_FB_EXT_BIT];
		end else if (ctrl_wr) begin
			fb_ext_q <= PWDATA[CTRL_FB_EXT_BIT];
		end
	end

	// writing lock and enable together leaves programming closed
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prog_en_q <= CTRL_RST[CTRL_PROG_EN_BIT];
		end else if (ctrl_wr) begin
			prog_en_q <= PWDATA[CTRL_PROG_EN_BIT] && !lock_q && !PWDATA[CTRL_LOCK_BIT];
		end
	end

	// lock is sticky until reset and also closes programming
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_q <= CTRL_RST[CTRL_LOCK_BIT];
		end else if (ctrl_wr) begin
			lock_q <= lock_q || PWDATA[CTRL_LOCK_BIT];
		end
	end

	// saturating count of accepted programming writes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prog_cnt_q <= 8'h00;
		end else if (cal_wr && prog_cnt_q != 8'hFF) begin
			prog_cnt_q <= prog_cnt_q + 8'h01;
		end
	end

	// gain trim source follows the feedback configuration
	assign gain_sel = fb_ext_q ? word_q[4][GAIN_EXT_LSB +: 4] : word_q[3][GAIN_INT_LSB +: 4]; // RULE_07 RULE_10

	// fields cut from the stored words
	assign temp_field = word_q[0][TEMP_LSB +: 10];
	assign osc_field = word_q[1][OSC_LSB +: 7];
	assign offs_field = word_q[2][OFFS_LSB +: 7];
	assign eaoff_field = word_q[3][EAOFF_LSB +: 5];
	assign span_field = word_q[4][SPAN_LSB +: 5];

	// field taps for the trim copies firmware makes; registered so they never glitch
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TEMP_READING_30C <= 10'h000;
		end else begin
			TEMP_READING_30C <= temp_field; // RULE_01
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			OSC_TRIM_FIELD <= 7'h00;
		end else begin
			OSC_TRIM_FIELD <= osc_field; // RULE_03
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SENSE_OFFSET_FIELD <= 7'h00;
		end else begin
			SENSE_OFFSET_FIELD <= offs_field; // RULE_04
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ERROR_AMP_OFFSET_TRIM <= 5'h00;
		end else begin
			ERROR_AMP_OFFSET_TRIM <= eaoff_field; // RULE_05 RULE_06
		end
	end

	// gain follows a path change one cycle after the control write
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			AMP_GAIN_TRIM <= 4'h0;
		end else begin
			AMP_GAIN_TRIM <= gain_sel;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			OVERVOLT_REF_SPAN_TRIM <= 5'h00;
		end else begin
			OVERVOLT_REF_SPAN_TRIM <= span_field; // RULE_08 RULE_09
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FB_EXTERNAL <= 1'b0;
		end else begin
			FB_EXTERNAL <= fb_ext_q;
		end
	end

endmodule

// ==== sim/fcw_cal_monitor.sv ====
`timescale 1ns/1ps
module fcw_cal_monitor (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [9:0] TEMP_READING_30C,
	input wire logic [6:0] OSC_TRIM_FIELD,
	input wire logic [4:0] ERROR_AMP_OFFSET_TRIM,
	input wire logic [3:0] AMP_GAIN_TRIM,
	input wire logic [4:0] OVERVOLT_REF_SPAN_TRIM,
	input wire logic FB_EXTERNAL
);
	wire rd = PSEL && PENABLE && PREADY && !PWRITE;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_temp_field: assert property (rd && PADDR == 32'h0000_8210 |-> PRDATA[9:0] == TEMP_READING_30C)
		else $error("temperature field differs");
	a_temp_zero: assert property (rd && PADDR == 32'h0000_8210 |-> PRDATA[31:10] == 22'h0)
		else $error("temperature upper bits set");
	a_osc_zero: assert property (rd && PADDR == 32'h0000_8214 |-> PRDATA == {25'h0, OSC_TRIM_FIELD})
		else $error("oscillator word wrong");
	a_offs_zero: assert property (rd && PADDR == 32'h0000_8218 |-> PRDATA[31:7] == 25'h0)
		else $error("offset word upper bits set");
	a_gain_word: assert property (rd && PADDR == 32'h0000_821C |-> PRDATA[4:0] == ERROR_AMP_OFFSET_TRIM
		&& (FB_EXTERNAL || PRDATA[11:8] == AMP_GAIN_TRIM) && PRDATA[31:12] == 20'h0 && PRDATA[7:5] == 3'h0)
		else $error("gain word wrong");
	a_span_word: assert property (rd && PADDR == 32'h0000_8220 |-> PRDATA[12:8] == OVERVOLT_REF_SPAN_TRIM
		&& (!FB_EXTERNAL || PRDATA[3:0] == AMP_GAIN_TRIM) && PRDATA[7:4] == 4'h0)
		else $error("span word wrong");
	a_ready_wait: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 !PREADY ##1 PREADY)
		else $error("ready latency wrong");
	a_unmapped_err: assert property (PREADY && PSEL && PADDR == 32'h0000_8300 |-> PSLVERR)
		else $error("unmapped access accepted");
endmodule
bind fcw_cal_store fcw_cal_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TEMP_READING_30C(TEMP_READING_30C), .OSC_TRIM_FIELD(OSC_TRIM_FIELD),
	.ERROR_AMP_OFFSET_TRIM(ERROR_AMP_OFFSET_TRIM), .AMP_GAIN_TRIM(AMP_GAIN_TRIM),
	.OVERVOLT_REF_SPAN_TRIM(OVERVOLT_REF_SPAN_TRIM), .FB_EXTERNAL(FB_EXTERNAL));

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, q;
	logic PREADY, PSLVERR, e, FB_EXTERNAL;
	logic [3:0] PSTRB = 4'hF, strb = 4'hF;
	logic [9:0] temp;
	logic [6:0] osc, offs;
	logic [4:0] eaoff, span;
	logic [3:0] gain;
	int fail_count = 0, samples_checked = 0;
	// unimplemented bits set in factory values so masking shows
	logic [31:0] exp_w [5] = '{32'h2BC, 32'h55, 32'h2A, 32'hA16, 32'h1509};
	fcw_cal_store #(.FACT_TEMP(14'h3ABC), .FACT_OSC(14'h2F55), .FACT_OFFS(14'h3F2A),
		.FACT_GEO(14'h3AF6), .FACT_SPAN(14'h35F9)) u_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TEMP_READING_30C(temp),
		.OSC_TRIM_FIELD(osc), .SENSE_OFFSET_FIELD(offs), .ERROR_AMP_OFFSET_TRIM(eaoff),
		.AMP_GAIN_TRIM(gain), .OVERVOLT_REF_SPAN_TRIM(span), .FB_EXTERNAL(FB_EXTERNAL));
	initial begin
		forever #4 CLK = ~CLK;
	end
	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// ready sampled at the rising edge; request stands until that edge, then released
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= strb;
		@(posedge CLK);
		PENABLE <= 1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			fail_count++;
			close_out();
		end
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		RST_N <= 1;
		for (int i = 0; i < 5; i++) begin
			apb(0, 32'h8210 + 32'(4 * i), 32'h0);
			check(q, exp_w[i]);
			check({31'h0, e}, 32'h0);
		end
		check({22'h0, temp}, 32'h2BC);
		check({25'h0, osc}, 32'h55);
		check({25'h0, offs}, 32'h2A);
		check({27'h0, eaoff}, 32'h16);
		check({28'h0, gain}, 32'hA);
		check({27'h0, span}, 32'h15);
		$display("factory words done");
		apb(1, 32'h8230, 32'h1);
		repeat (2) @(negedge CLK);
		check({31'h0, FB_EXTERNAL}, 32'h1);
		check({28'h0, gain}, 32'h9);
		apb(0, 32'h8220, 32'h0);
		check(q, 32'h1509);
		$display("gain select done");
		apb(1, 32'h8210, 32'hFFFF_FFFF);
		check({31'h0, e}, 32'h1);
		apb(0, 32'h8210, 32'h0);
		check(q, 32'h2BC);
		apb(1, 32'h8230, 32'h3);
		apb(1, 32'h8210, 32'hFFFF_FFFF);
		apb(0, 32'h8210, 32'h0);
		check(q, 32'h3FF);
		apb(1, 32'h821C, 32'hFFFF_FFFF);
		apb(0, 32'h821C, 32'h0);
		check(q, 32'hF1F);
		apb(0, 32'h8300, 32'h0);
		check({e, q[30:0]}, 32'h8000_0000);
		$display("write and error cases done");
		strb = 4'h1;
		apb(1, 32'h8220, 32'hFFFF_FFFF);
		strb = 4'hF;
		apb(0, 32'h8220, 32'h0);
		check(q, 32'h150F);
		check({28'h0, gain}, 32'hF);
		apb(1, 32'h8230, 32'h7);
		apb(1, 32'h8214, 32'hFFFF_FFFF);
		check({31'h0, e}, 32'h1);
		apb(0, 32'h8234, 32'h0);
		check(q, 32'h305);
		apb(0, 32'h8238, 32'h0);
		check(q, 32'h0015_1F0F);
		$display("strobe lock and status done");
		@(posedge CLK);
		RST_N <= 0;
		repeat (2) @(posedge CLK);
		RST_N <= 1;
		for (int i = 0; i < 5; i++) begin
			apb(0, 32'h8210 + 32'(4 * i), 32'h0);
			check(q, exp_w[i]);
		end
		check({25'h0, osc}, 32'h55);
		check({31'h0, FB_EXTERNAL}, 32'h0);
		$display("reset reload done");
		close_out();
	end
endmodule
